// ==== core/ssrp_addr_step.v ====
// Next-address function of the three auto-increment lines
`include "ssrp_consts.vh"
module ssrp_addr_step (
    input wire [6:0] i_addr,
    input wire i_fifo_en,
    output reg [6:0] o_next
);
    // Wrap targets per line; unknown addresses simply count up
    always @*
    begin
        if (i_addr == `SSRP_ADDR_LOW_GAP)
            o_next = `SSRP_ADDR_LOW_RESUME;
        else if (i_addr == `SSRP_ADDR_LOW_LAST)
            o_next = i_fifo_en ? `SSRP_ADDR_FIFO_WRAP : `SSRP_ADDR_LOW_FIRST;
        else if (i_addr == `SSRP_ADDR_CTRL_LAST)
            o_next = `SSRP_ADDR_CTRL_FIRST;
        else if (i_addr == `SSRP_ADDR_ADJ_LAST)
            o_next = `SSRP_ADDR_ADJ_FIRST;
        else
            o_next = i_addr + 7'h01;
    end
endmodule

// ==== core/ssrp_consts.vh ====
// Constants for the serial register port: address lines, slave address, link timing
`ifndef SSRP_CONSTS_VH
`define SSRP_CONSTS_VH
`define SSRP_ADDR_LOW_FIRST 7'h00
`define SSRP_ADDR_LOW_GAP 7'h03
`define SSRP_ADDR_LOW_RESUME 7'h10
`define SSRP_ADDR_LOW_LAST 7'h18
`define SSRP_ADDR_FIFO_WRAP 7'h11
`define SSRP_ADDR_CTRL_FIRST 7'h30
`define SSRP_ADDR_CTRL_LAST 7'h32
`define SSRP_ADDR_CTRL_SEL_LAST 7'h37
`define SSRP_ADDR_RSV_FIRST 7'h33
`define SSRP_ADDR_RSV_LAST 7'h35
`define SSRP_ADDR_ADJ_FIRST 7'h60
`define SSRP_ADDR_ADJ_LAST 7'h62
`define SSRP_SLAVE_PREFIX 5'h03
`define SSRP_HS_CODE_PREFIX 5'h01
`define SSRP_SPI_BITS 5'h10
`define SSRP_SPI_ADDR_BITS 5'h08
`define SSRP_SPI_NEXT_EDGE 5'h0F
`define SSRP_STD_KHZ 100
`define SSRP_FAST_KHZ 400
`define SSRP_HS_KHZ 2500
`define SSRP_REF_KHZ 20000
`endif

// ==== core/ssrp_port.v ====
// Serial register port: shift-interface read side and two-wire bus slave
// Operation
// - Shift read: flag, address, then MSB-first byte
// - Continued clocking reads next address after 16th
// - Chip select rising floats shift data output
// - Low line steps 03h to 10h, wraps 00h
// - FIFO enabled: 18h wraps to 11h
// - Control and adjustment lines wrap within three
// - Unmapped shift address leaves output floating
// - Two-wire slave runs to 2.5 MHz
// - Data high-clock edges mark START or STOP
// - Slave address 00011 plus two strap bits
// - Acknowledge only matching address, then read/write
// - Write: register address byte, then data bytes
// - Further write bytes go to next address
// - Writes reach only read/write registers
// - Read continues on master acknowledge only
// - Sample rising, shift falling, chip select low
// - Counter holds address after last access
// - Random read: write header, repeated START, read
// - Master code unacknowledged, high speed until STOP
`include "ssrp_consts.vh"
module ssrp_port (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire i_shift_clock_pin,
    input wire i_chip_select_low_pin,
    input wire i_sdi,
    output reg o_sdo,
    output reg o_sdo_oe,
    input wire i_scl,
    input wire i_sda,
    output wire o_sda_out,
    output reg o_sda_oe,
    input wire i_address_strap_bit0,
    input wire i_address_strap_bit1,
    input wire i_fifo_en,
    input wire [7:0] i_rd_data,
    output reg [6:0] o_reg_addr,
    output reg [7:0] o_wr_data,
    output reg o_wr_strobe,
    output reg o_hs_mode
);
    localparam ST_IDLE = 3'h0;
    localparam ST_DEV = 3'h1;
    localparam ST_ACK = 3'h2;
    localparam ST_RX = 3'h3;
    localparam ST_TX = 3'h4;
    localparam ST_MACK = 3'h5;
    localparam ST_WAIT = 3'h6;

    // Two-stage synchronisers; the 20 MHz clock oversamples the 2.5 MHz link
    reg [6:0] s1_reg;
    reg [6:0] s2_reg;
    reg [4:0] s3_reg;
    always @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            s1_reg <= 7'h7F;
            s2_reg <= 7'h7F;
            s3_reg <= 5'h1F;
        end
        else
        begin
            s1_reg <= {i_address_strap_bit1, i_address_strap_bit0, i_shift_clock_pin,
                i_chip_select_low_pin, i_sdi, i_scl, i_sda};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg[4:0];
        end
    end
    wire sk = s2_reg[4];
    wire cs_n = s2_reg[3];
    wire sdi = s2_reg[2];
    wire scl = s2_reg[1];
    wire sda = s2_reg[0];
    wire sk_rise = sk & ~s3_reg[4];
    wire sk_fall = ~sk & s3_reg[4];
    wire cs_rise = cs_n & ~s3_reg[3];
    wire scl_rise = scl & ~s3_reg[1];
    wire scl_fall = ~scl & s3_reg[1];
    wire start_det = scl & s3_reg[1] & ~sda & s3_reg[0];
    wire stop_det = scl & s3_reg[1] & sda & ~s3_reg[0];

    // Shared address counter, stepped along its line
    reg [6:0] addr_reg;
    wire [6:0] addr_inc;
    ssrp_addr_step ssrp_addr_step_i (
        .i_addr(addr_reg),
        .i_fifo_en(i_fifo_en),
        .o_next(addr_inc)
    );

    // Shift interface and two-wire slave state
    reg [4:0] sk_cnt_reg;
    reg [7:0] sh_reg;
    reg spi_rd_reg;
    reg spi_sel_reg;
    reg [2:0] st_reg;
    reg [3:0] bit_reg;
    reg [7:0] rx_reg;
    reg [7:0] tx_reg;
    reg first_reg;
    reg rd_reg;
    assign o_sda_out = 1'b0;
    // Selection check; reserved test addresses still count as selected
    wire [6:0] spi_addr = {sh_reg[5:0], sdi};
    wire spi_hit = (spi_addr <= `SSRP_ADDR_LOW_LAST) ||
        ((spi_addr >= `SSRP_ADDR_CTRL_FIRST) && (spi_addr <= `SSRP_ADDR_CTRL_SEL_LAST)) ||
        ((spi_addr >= `SSRP_ADDR_ADJ_FIRST) && (spi_addr <= `SSRP_ADDR_ADJ_LAST));
    // Only 30h to 37h take writes; the rest of the map is read-only
    wire wr_hit = (addr_reg >= `SSRP_ADDR_CTRL_FIRST) &&
        (addr_reg <= `SSRP_ADDR_CTRL_SEL_LAST);

    always @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sk_cnt_reg <= 5'h00;
            sh_reg <= 8'h00;
            spi_rd_reg <= 1'b0;
            spi_sel_reg <= 1'b0;
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
            addr_reg <= 7'h00;
            o_reg_addr <= 7'h00;
            o_wr_data <= 8'h00;
            o_wr_strobe <= 1'b0;
            o_hs_mode <= 1'b0;
            st_reg <= ST_IDLE;
            bit_reg <= 4'h0;
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
            first_reg <= 1'b0;
            rd_reg <= 1'b0;
            o_sda_oe <= 1'b0;
        end
        else
        begin
            o_wr_strobe <= 1'b0;
            // Shift read: capture on rising, shift out on falling
            if (cs_n)
            begin
                sk_cnt_reg <= 5'h00;
                spi_sel_reg <= 1'b0;
                if (cs_rise)
                    o_sdo_oe <= 1'b0;
            end
            else if (sk_rise)
            begin
                if (sk_cnt_reg < `SSRP_SPI_ADDR_BITS)
                    sh_reg <= {sh_reg[6:0], sdi};
                if (sk_cnt_reg == `SSRP_SPI_ADDR_BITS - 5'h01)
                begin
                    spi_rd_reg <= sh_reg[6];
                    addr_reg <= spi_addr;
                    o_reg_addr <= spi_addr;
                    spi_sel_reg <= spi_hit;
                end
                if (sk_cnt_reg != `SSRP_SPI_BITS - 5'h01)
                    sk_cnt_reg <= sk_cnt_reg + 5'h01;
                else
                    sk_cnt_reg <= `SSRP_SPI_ADDR_BITS;
            end
            else if (sk_fall && spi_rd_reg && spi_sel_reg && sk_cnt_reg >= `SSRP_SPI_ADDR_BITS)
            begin
                o_sdo_oe <= 1'b1;
                if (sk_cnt_reg == `SSRP_SPI_ADDR_BITS)
                begin
                    // Byte starts after 8th clock, or after 16th on a sequential read
                    o_sdo <= i_rd_data[7];
                    tx_reg <= {i_rd_data[6:0], 1'b0};
                    addr_reg <= addr_inc;
                    o_reg_addr <= addr_inc;
                end
                else
                begin
                    o_sdo <= tx_reg[7];
                    tx_reg <= {tx_reg[6:0], 1'b0};
                end
            end
            // Two-wire slave; START and STOP override every state
            if (stop_det)
            begin
                st_reg <= ST_IDLE;
                o_sda_oe <= 1'b0;
                o_hs_mode <= 1'b0;
            end
            else if (start_det)
            begin
                st_reg <= ST_DEV;
                bit_reg <= 4'h0;
                o_sda_oe <= 1'b0;
            end
            else if (cs_n)
            begin
                case (st_reg)
                    ST_DEV, ST_RX:
                    begin
                        if (scl_rise)
                        begin
                            rx_reg <= {rx_reg[6:0], sda};
                            bit_reg <= bit_reg + 4'h1;
                        end
                        else if (scl_fall && bit_reg == 4'h8)
                        begin
                            bit_reg <= 4'h0;
                            if (st_reg == ST_DEV)
                            begin
                                if (rx_reg[7:3] == `SSRP_HS_CODE_PREFIX)
                                begin
                                    o_hs_mode <= 1'b1;
                                    st_reg <= ST_WAIT;
                                end
                                else if (rx_reg[7:1] == {`SSRP_SLAVE_PREFIX, s2_reg[6:5]})
                                begin
                                    rd_reg <= rx_reg[0];
                                    o_reg_addr <= addr_reg;
                                    first_reg <= 1'b1;
                                    o_sda_oe <= 1'b1;
                                    st_reg <= ST_ACK;
                                end
                                else
                                    st_reg <= ST_WAIT;
                            end
                            else
                            begin
                                if (first_reg)
                                begin
                                    addr_reg <= rx_reg[6:0];
                                    o_reg_addr <= rx_reg[6:0];
                                end
                                else
                                begin
                                    o_reg_addr <= addr_reg;
                                    o_wr_data <= rx_reg;
                                    o_wr_strobe <= wr_hit;
                                    addr_reg <= addr_inc;
                                end
                                first_reg <= 1'b0;
                                o_sda_oe <= 1'b1;
                                st_reg <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        // Release acknowledge at the falling edge closing the ninth clock
                        if (scl_fall)
                        begin
                            if (rd_reg)
                            begin
                                o_reg_addr <= addr_inc;
                                o_sda_oe <= ~i_rd_data[7];
                                tx_reg <= {i_rd_data[6:0], 1'b1};
                                addr_reg <= addr_inc;
                                bit_reg <= 4'h1;
                                st_reg <= ST_TX;
                            end
                            else
                            begin
                                o_sda_oe <= 1'b0;
                                st_reg <= ST_RX;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_reg == 4'h8)
                            begin
                                o_sda_oe <= 1'b0;
                                st_reg <= ST_MACK;
                            end
                            else
                            begin
                                o_sda_oe <= ~tx_reg[7];
                                tx_reg <= {tx_reg[6:0], 1'b1};
                                bit_reg <= bit_reg + 4'h1;
                            end
                        end
                    end
                    ST_MACK:
                    begin
                        if (scl_rise)
                            st_reg <= sda ? ST_WAIT : ST_ACK;
                    end
                    ST_WAIT:
                        o_sda_oe <= 1'b0;
                    default:
                        st_reg <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ==== tb/ssrp_host.sv ====
// Host model driving the shift interface and the two-wire bus
module ssrp_host (
    input wire logic clk,
    output logic sk,
    output logic cs_n,
    output logic sdi,
    input wire logic so,
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int H = 10;
    logic [7:0] rx [0:3];
    logic got;
    // Both links idle high; SK stands still outside frames
    initial
    begin
        sk = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b1;
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Read frame: flag and address, then n bytes sampled on SK rise
    task automatic spi_read(input logic [6:0] a, input int n);
        logic [7:0] hdr;
        hdr = {1'b1, a};
        cs_n <= 1'b0;
        tick(4);
        for (int i = 0; i < 8 + 8 * n; i++)
        begin
            sk <= 1'b0;
            if (i < 8)
                sdi <= hdr[7 - i];
            tick(4);
            if (i >= 8)
                rx[i / 8 - 1][7 - i % 8] = so;
            sk <= 1'b1;
            tick(4);
        end
        cs_n <= 1'b1;
        tick(8);
    endtask
    // Data moves only while SCL is low, with margin after the fall
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        tick(H);
        scl <= 1'b1;
        tick(H);
        r = sda;
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic start();
        sda_low <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(H);
        sda_low <= 1'b1;
        tick(H);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        tick(H);
        scl <= 1'b1;
        tick(H);
        sda_low <= 1'b0;
        tick(H);
    endtask
    task automatic wr(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        got = !r;
    endtask
    task automatic rd(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!ack, r);
    endtask
endmodule

// ==== tb/ssrp_port_sva.sv ====
// Concurrent checks on the serial register port pins
module ssrp_port_sva (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire i_chip_select_low_pin,
    input wire i_scl,
    input wire i_sda,
    input wire o_sdo_oe,
    input wire o_sda_out,
    input wire o_sda_oe,
    input wire [6:0] o_reg_addr,
    input wire o_wr_strobe,
    input wire o_hs_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    // Windows of six cycles cover the two-stage pin synchronisers
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    AST_SDO_FLOAT: assert property (i_chip_select_low_pin [*6] |-> !o_sdo_oe)
        else $error("shift data driven while deselected");
    AST_SDO_SPI_ONLY: assert property (o_sdo_oe |-> !$past(i_chip_select_low_pin, 6))
        else $error("shift data driven without a frame");
    AST_SDA_QUIET_SPI: assert property ((!i_chip_select_low_pin) [*6] |-> !o_sda_oe)
        else $error("two-wire data driven during a shift frame");
    AST_SDA_OPEN_DRAIN: assert property (o_sda_oe |-> !o_sda_out)
        else $error("two-wire data driven high");
    AST_ACK_SCL_LOW: assert property ($rose(o_sda_oe) |-> !i_scl)
        else $error("two-wire data changed with clock high");
    AST_STROBE_PULSE: assert property (o_wr_strobe |=> !o_wr_strobe)
        else $error("write strobe longer than one cycle");
    AST_STROBE_RANGE: assert property (o_wr_strobe |-> o_reg_addr inside {[7'h30:7'h37]})
        else $error("write strobe outside writable range");
    AST_HS_STOP: assert property (i_scl && $rose(i_sda) |-> ##[1:6] !o_hs_mode)
        else $error("high speed kept after stop");
    AST_HS_NO_ACK: assert property ($rose(o_hs_mode) |-> !o_sda_oe)
        else $error("master code acknowledged");
    cover property ($rose(o_sdo_oe));
    cover property (o_wr_strobe);
    cover property ($rose(o_hs_mode));
endmodule
bind ssrp_port ssrp_port_sva ssrp_port_sva_i (.*);

// ==== tb/ssrp_port_tb.sv ====
// Self-checking bench for the serial register port
module ssrp_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic arst_n;
    logic fifo_en;
    logic strap0;
    logic strap1;
    wire logic sk, cs_n, sdi, scl, sda_low, sdo, sdo_oe, sda_out, sda_oe, wr_strobe, hs_mode;
    wire logic [6:0] reg_addr;
    wire logic [7:0] wr_data;
    // Floating shift output reads as Z so it never passes for data
    wire logic so = sdo_oe ? sdo : 1'bz;
    wire logic sda = !(sda_low || (sda_oe && !sda_out));
    wire logic [7:0] rd_data = {1'b1, reg_addr};
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    logic [6:0] wa [$];
    logic [7:0] wd [$];
    ssrp_port ssrp_port_i (.i_ref_clk(clk), .i_arst_n(arst_n), .i_shift_clock_pin(sk),
        .i_chip_select_low_pin(cs_n), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_scl(scl),
        .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_address_strap_bit0(strap0),
        .i_address_strap_bit1(strap1), .i_fifo_en(fifo_en), .i_rd_data(rd_data),
        .o_reg_addr(reg_addr), .o_wr_data(wr_data), .o_wr_strobe(wr_strobe), .o_hs_mode(hs_mode));
    ssrp_host ssrp_host_i (.clk(clk), .sk(sk), .cs_n(cs_n), .sdi(sdi), .so(so), .scl(scl),
        .sda_low(sda_low), .sda(sda));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Log every write strobe; the cycle limit cuts a hang short
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (wr_strobe === 1'b1)
        begin
            wa.push_back(reg_addr);
            wd.push_back(wr_data);
        end
        if (cyc == 30000)
        begin
            errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [6:0] nxt(input logic [6:0] a, input logic f);
        case (a)
            7'h03: return 7'h10;
            7'h18: return f ? 7'h11 : 7'h00;
            7'h32: return 7'h30;
            7'h62: return 7'h60;
            default: return a + 7'h01;
        endcase
    endfunction
    // Bit 7 of each entry is the FIFO enable for that run
    task automatic t_spi_seq();
        logic [7:0] st [6] = '{8'h03, 8'h18, 8'h98, 8'h32, 8'h62, 8'h82};
        logic [6:0] a;
        foreach (st[k])
        begin
            fifo_en <= st[k][7];
            @(posedge clk);
            a = st[k][6:0];
            ssrp_host_i.spi_read(a, 3);
            for (int j = 0; j < 3; j++)
            begin
                chk("spi byte", {1'b1, a}, ssrp_host_i.rx[j]);
                a = nxt(a, st[k][7]);
            end
            chk("sdo enable", 8'h00, {7'h00, sdo_oe});
        end
    endtask
    task automatic t_spi_unmapped();
        logic [6:0] bad [4] = '{7'h19, 7'h2F, 7'h38, 7'h63};
        foreach (bad[k])
        begin
            ssrp_host_i.spi_read(bad[k], 1);
            chk("unmapped read", 8'hZZ, ssrp_host_i.rx[0]);
        end
    endtask
    // Every strap setting against every candidate address
    task automatic t_i2c_match();
        for (int p = 0; p < 4; p++)
        begin
            strap1 <= p[1];
            strap0 <= p[0];
            for (int s = 0; s < 4; s++)
            begin
                ssrp_host_i.start();
                ssrp_host_i.wr({5'h03, s[1:0], 1'b0});
                chk("address ack", {7'h00, s == p}, {7'h00, ssrp_host_i.got});
                ssrp_host_i.stop();
            end
        end
    endtask
    task automatic send(input logic [6:0] ra, input int n);
        ssrp_host_i.start();
        ssrp_host_i.wr({5'h03, strap1, strap0, 1'b0});
        chk("slave ack", 8'h01, {7'h00, ssrp_host_i.got});
        ssrp_host_i.wr({1'b0, ra});
        chk("address byte ack", 8'h01, {7'h00, ssrp_host_i.got});
        for (int k = 0; k < n; k++)
        begin
            ssrp_host_i.wr(8'hA0 + 8'(k));
            chk("data ack", 8'h01, {7'h00, ssrp_host_i.got});
        end
    endtask
    // Control line wraps; bytes to read-only places leave no strobe
    task automatic t_i2c_write();
        logic [6:0] a;
        wa.delete();
        wd.delete();
        send(7'h31, 3);
        ssrp_host_i.stop();
        send(7'h10, 2);
        ssrp_host_i.stop();
        chk("strobe count", 8'h03, 8'(wa.size()));
        a = 7'h31;
        for (int k = 0; k < 3; k++)
        begin
            chk("strobe addr", {1'b0, a}, {1'b0, wa[k]});
            chk("strobe data", 8'hA0 + 8'(k), wd[k]);
            a = nxt(a, 1'b0);
        end
    endtask
    // Random read over the 18h wrap with FIFO on, then a read with no address phase
    task automatic t_i2c_read();
        logic [7:0] q;
        logic [6:0] a;
        fifo_en <= 1'b1;
        send(7'h17, 0);
        ssrp_host_i.start();
        ssrp_host_i.wr({5'h03, strap1, strap0, 1'b1});
        a = 7'h17;
        for (int k = 0; k < 3; k++)
        begin
            ssrp_host_i.rd(k < 2, q);
            chk("read byte", {1'b1, a}, q);
            a = nxt(a, 1'b1);
        end
        chk("sda after nack", 8'h00, {7'h00, sda_oe});
        ssrp_host_i.stop();
        ssrp_host_i.start();
        ssrp_host_i.wr({5'h03, strap1, strap0, 1'b1});
        ssrp_host_i.rd(1'b0, q);
        ssrp_host_i.stop();
        chk("current read", {1'b1, a}, q);
    endtask
    task automatic t_hs();
        ssrp_host_i.start();
        ssrp_host_i.wr(8'h0B);
        chk("master code ack", 8'h00, {7'h00, ssrp_host_i.got});
        chk("high speed set", 8'h01, {7'h00, hs_mode});
        ssrp_host_i.stop();
        chk("high speed at stop", 8'h00, {7'h00, hs_mode});
    endtask
    initial
    begin
        arst_n = 1'b0;
        fifo_en = 1'b0;
        strap0 = 1'b0;
        strap1 = 1'b1;
        repeat (19) @(posedge clk);
        chk("reset outputs", 8'h00, {4'h0, sdo_oe, sda_oe, wr_strobe, hs_mode});
        @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_spi_seq();
        t_spi_unmapped();
        t_i2c_match();
        t_i2c_write();
        t_i2c_read();
        t_hs();
        end_of_test();
    end
endmodule
